// file: adc_pins_defs.svh
`ifndef ADC_PINS_DEFS_SVH
`define ADC_PINS_DEFS_SVH
`define REG_SERIAL_CFG 8'h01
`define REG_BUS_CFG    8'h02
`define REG_REF_CFG    8'h05
`define REG_IRQ_STATUS 8'h10
`define REG_IRQ_MASK   8'h11
`define BIT_FOUR_PIN   0
`define BIT_SINGLE_BUS 0
`define BIT_EXT_REF    2
`define BIT_SYNC_MODE  3
`define BIT_PWR_DOWN   6
`define IRQ_REALIGN    0
`define IRQ_OVR_A      1
`define IRQ_OVR_B      2
`define IRQ_SERIAL_WR  3
`define REG_RESET      8'h00
`define SAMPLE_ZERO    12'h000
`define SER_CMD_LAST   4'h7
`define SER_FRAME_LAST 4'hf
`endif

// file: adc_pins_pkg.sv
package adc_pins_pkg;

  typedef enum logic [2:0] {
    SER_IDLE = 3'h1,
    SER_CMD  = 3'h2,
    SER_DATA = 3'h4
  } ser_state_e;

  typedef struct packed {
    logic [1:0]  single_sync;
    logic [1:0]  extref_sync;
    logic [1:0]  pwr_sync;
    logic [1:0]  realign_p_sync;
    logic [1:0]  realign_n_sync;
    logic [1:0]  sclk_sync;
    logic [1:0]  sen_sync;
    logic [1:0]  sdio_sync;
    logic        realign_prev;
    logic        sclk_prev;
    logic [7:0]  serial_cfg;
    logic [7:0]  bus_cfg;
    logic [7:0]  ref_cfg;
    logic [7:0]  irq_status;
    logic [7:0]  irq_mask;
    logic [7:0]  rdata;
    ser_state_e  ser_state;
    logic [3:0]  bit_cnt;
    logic [15:0] shift;
    logic [7:0]  out_shift;
    logic        read_op;
    logic        sdio_o;
    logic        sdio_oe;
    logic        sdo_o;
    logic        sdo_oe;
    logic        clk_a;
    logic        clk_b;
    logic [11:0] data_a;
    logic [11:0] data_b;
    logic        ovr_a;
    logic        ovr_b;
    logic        ovr_a_n;
    logic        ovr_b_n;
    logic        single_bus;
    logic        ext_ref;
    logic        pwr_down;
    logic        irq;
  } state_s;

endpackage

// file: adc_ctrl_pins.sv
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "adc_pins_defs.svh"

module adc_ctrl_pins (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_b_in,
  // control pins
  input  wire logic        single_bus_select_pin_in,
  input  wire logic        external_reference_select_pin_in,
  input  wire logic        power_down_pin_in,
  input  wire logic        realign_in_pos_in,
  input  wire logic        realign_in_neg_in,
  // converter core
  input  wire logic [11:0] sample_a_in,
  input  wire logic [11:0] sample_b_in,
  input  wire logic        over_range_a_in,
  input  wire logic        over_range_b_in,
  // serial port
  input  wire logic        serial_clock_in,
  input  wire logic        serial_enable_n_in,
  input  wire logic        serial_io_in,
  output logic             serial_io_out,
  output logic             serial_io_oe_out,
  output logic             serial_data_out,
  output logic             serial_data_oe_out,
  // register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [7:0]       reg_rdata_out,
  // output buses
  output logic [11:0]      data_a_out,
  output logic [11:0]      data_b_out,
  output logic             data_ready_clock_a_out,
  output logic             data_ready_clock_b_out,
  output logic             overrange_a_pos_out,
  output logic             overrange_a_neg_out,
  output logic             overrange_b_pos_out,
  output logic             overrange_b_neg_out,
  // mode levels and interrupt
  output logic             single_bus_out,
  output logic             external_reference_out,
  output logic             power_down_out,
  output logic             irq_out
);

  adc_pins_pkg::state_s st;
  adc_pins_pkg::state_s st_next;

  function automatic logic [7:0] reg_read(adc_pins_pkg::state_s s, logic [7:0] a);
    case (a)
      `REG_SERIAL_CFG: return s.serial_cfg;
      `REG_BUS_CFG:    return s.bus_cfg;
      `REG_REF_CFG:    return s.ref_cfg;
      `REG_IRQ_STATUS: return s.irq_status;
      `REG_IRQ_MASK:   return s.irq_mask;
      default:         return `REG_RESET;
    endcase
  endfunction

  function automatic adc_pins_pkg::state_s apply_write(adc_pins_pkg::state_s s,
                                                      logic [7:0] a, logic [7:0] d);
    adc_pins_pkg::state_s r;
    r = s;
    case (a)
      `REG_SERIAL_CFG: r.serial_cfg = d;
      `REG_BUS_CFG:    r.bus_cfg = d;
      `REG_REF_CFG:    r.ref_cfg = d;
      `REG_IRQ_STATUS: r.irq_status = s.irq_status & ~d;
      `REG_IRQ_MASK:   r.irq_mask = d;
      default:         r = s;
    endcase
    return r;
  endfunction

  always_comb begin
    logic        realign_lvl;
    logic        realign_rise;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        sen_active;
    logic        four_pin;
    logic        sync_mode;
    logic [7:0]  events;
    logic [7:0]  cmd;
    logic [15:0] frame;
    realign_lvl  = st.realign_p_sync[1] & ~st.realign_n_sync[1];
    realign_rise = realign_lvl & ~st.realign_prev;
    sclk_rise    = st.sclk_sync[1] & ~st.sclk_prev;
    sclk_fall    = ~st.sclk_sync[1] & st.sclk_prev;
    sen_active   = ~st.sen_sync[1];
    four_pin     = st.serial_cfg[`BIT_FOUR_PIN];
    sync_mode    = st.ref_cfg[`BIT_SYNC_MODE];
    events       = `REG_RESET;
    cmd          = {st.shift[6:0], st.sdio_sync[1]};
    frame        = {st.shift[14:0], st.sdio_sync[1]};
    st_next      = st;

    // every control and serial pin from outside passes two flops before use
    st_next.single_sync    = {st.single_sync[0], single_bus_select_pin_in};
    st_next.extref_sync    = {st.extref_sync[0], external_reference_select_pin_in};
    st_next.pwr_sync       = {st.pwr_sync[0], power_down_pin_in};
    st_next.realign_p_sync = {st.realign_p_sync[0], realign_in_pos_in};
    st_next.realign_n_sync = {st.realign_n_sync[0], realign_in_neg_in};
    st_next.sclk_sync      = {st.sclk_sync[0], serial_clock_in};
    st_next.sen_sync       = {st.sen_sync[0], serial_enable_n_in};
    st_next.sdio_sync      = {st.sdio_sync[0], serial_io_in};
    st_next.realign_prev   = realign_lvl;
    st_next.sclk_prev      = st.sclk_sync[1];

    st_next.single_bus = st.single_sync[1] | st.bus_cfg[`BIT_SINGLE_BUS];
    st_next.ext_ref    = st.extref_sync[1] | st.ref_cfg[`BIT_EXT_REF];
    st_next.pwr_down   = st.pwr_sync[1] | st.ref_cfg[`BIT_PWR_DOWN];

    // serial frame: r/w bit, 7-bit address, 8 data bits, msb first
    case (st.ser_state)
      adc_pins_pkg::SER_IDLE: begin
        st_next.bit_cnt = 4'h0;
        st_next.read_op = 1'b0;
        if (sen_active) begin
          st_next.ser_state = adc_pins_pkg::SER_CMD;
        end
      end
      adc_pins_pkg::SER_CMD: begin
        if (sclk_rise) begin
          st_next.shift   = frame;
          st_next.bit_cnt = st.bit_cnt + 4'h1;
          if (st.bit_cnt == `SER_CMD_LAST) begin
            st_next.read_op   = cmd[7];
            st_next.out_shift = reg_read(st, {1'b0, cmd[6:0]});
            st_next.ser_state = adc_pins_pkg::SER_DATA;
          end
        end
      end
      adc_pins_pkg::SER_DATA: begin
        // read data changes on the falling edge so the host samples it stable
        if (sclk_fall && st.read_op) begin
          st_next.out_shift = {st.out_shift[6:0], 1'b0};
          if (four_pin) begin
            st_next.sdo_o  = st.out_shift[7];
            st_next.sdo_oe = 1'b1;
          end else begin
            st_next.sdio_o  = st.out_shift[7];
            st_next.sdio_oe = 1'b1;
          end
        end
        if (sclk_rise) begin
          st_next.shift   = frame;
          st_next.bit_cnt = st.bit_cnt + 4'h1;
          if (st.bit_cnt == `SER_FRAME_LAST) begin
            if (!st.read_op) begin
              st_next = apply_write(st_next, {1'b0, frame[14:8]}, frame[7:0]);
              events[`IRQ_SERIAL_WR] = 1'b1;
            end
            st_next.ser_state = adc_pins_pkg::SER_IDLE;
          end
        end
      end
      default: begin
        st_next.ser_state = adc_pins_pkg::SER_IDLE;
      end
    endcase
    if (!sen_active) begin
      st_next.ser_state = adc_pins_pkg::SER_IDLE;
      st_next.sdio_oe   = 1'b0;
      st_next.sdo_oe    = 1'b0;
    end
    if (four_pin) begin
      st_next.sdio_oe = 1'b0;
    end else begin
      st_next.sdo_oe = 1'b0;
    end

    // port write lands after a serial write in the same cycle, so the port wins
    if (reg_wr_in) begin
      st_next = apply_write(st_next, reg_addr_in, reg_wdata_in);
    end
    st_next.rdata = reg_rd_in ? reg_read(st, reg_addr_in) : `REG_RESET;

    // output buses; sleep parks data, clocks and true overrange pins low, complements high
    if (st.pwr_down) begin
      st_next.data_a = `SAMPLE_ZERO;
      st_next.data_b = `SAMPLE_ZERO;
      st_next.clk_a  = 1'b0;
      st_next.clk_b  = 1'b0;
      st_next.ovr_a  = 1'b0;
      st_next.ovr_b  = 1'b0;
    end else begin
      st_next.data_a = sample_a_in;
      st_next.clk_a  = realign_lvl ? 1'b0 : ~st.clk_a;
      st_next.ovr_a  = sync_mode ? realign_rise : over_range_a_in;
      events[`IRQ_OVR_A] = over_range_a_in & ~sync_mode;
      if (st.single_bus) begin
        st_next.data_b = `SAMPLE_ZERO;
        st_next.clk_b  = 1'b0;
        st_next.ovr_b  = 1'b0;
      end else begin
        st_next.data_b = sample_b_in;
        st_next.clk_b  = realign_lvl ? 1'b0 : ~st.clk_b;
        st_next.ovr_b  = sync_mode ? realign_rise : over_range_b_in;
        events[`IRQ_OVR_B] = over_range_b_in & ~sync_mode;
      end
    end
    // complements get their own flops so every pin leaves straight from a register
    st_next.ovr_a_n = ~st_next.ovr_a;
    st_next.ovr_b_n = ~st_next.ovr_b;
    events[`IRQ_REALIGN] = realign_rise;

    // set wins over a write-one clear in the same cycle
    st_next.irq_status = st_next.irq_status | events;
    st_next.irq        = |(st.irq_status & st.irq_mask);

    if (!rst_b_in) begin
      st_next           = '0;
      st_next.ser_state = adc_pins_pkg::SER_IDLE;
      st_next.sen_sync  = 2'h3;
      st_next.ovr_a_n   = 1'b1;
      st_next.ovr_b_n   = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    st <= st_next;
  end

  assign serial_io_out          = st.sdio_o;
  assign serial_io_oe_out       = st.sdio_oe;
  assign serial_data_out        = st.sdo_o;
  assign serial_data_oe_out     = st.sdo_oe;
  assign reg_rdata_out          = st.rdata;
  assign data_a_out             = st.data_a;
  assign data_b_out             = st.data_b;
  assign data_ready_clock_a_out = st.clk_a;
  assign data_ready_clock_b_out = st.clk_b;
  assign overrange_a_pos_out    = st.ovr_a;
  assign overrange_a_neg_out    = st.ovr_a_n;
  assign overrange_b_pos_out    = st.ovr_b;
  assign overrange_b_neg_out    = st.ovr_b_n;
  assign single_bus_out         = st.single_bus;
  assign external_reference_out = st.ext_ref;
  assign power_down_out         = st.pwr_down;
  assign irq_out                = st.irq;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  property p_single_pin;
    single_bus_select_pin_in [*3] |=> single_bus_out;
  endproperty
  a_single_pin: assert property (p_single_pin) else $error("single bus pin ignored");

  property p_single_b_idle;
    single_bus_out && !power_down_out |=> data_b_out == `SAMPLE_ZERO && !data_ready_clock_b_out;
  endproperty
  a_single_b_idle: assert property (p_single_b_idle) else $error("bus b active");

  property p_ext_ref_bit;
    st.ref_cfg[`BIT_EXT_REF] |=> external_reference_out;
  endproperty
  a_ext_ref_bit: assert property (p_ext_ref_bit) else $error("ext ref bit ignored");

  property p_pwr_pin;
    power_down_pin_in [*3] |=> power_down_out ##1 data_a_out == `SAMPLE_ZERO;
  endproperty
  a_pwr_pin: assert property (p_pwr_pin) else $error("power down not entered");

  property p_ovr_a;
    !st.ref_cfg[`BIT_SYNC_MODE] && !power_down_out && over_range_a_in
      |=> overrange_a_pos_out && !overrange_a_neg_out;
  endproperty
  a_ovr_a: assert property (p_ovr_a) else $error("overrange a missing");

  property p_sync_marker;
    st.ref_cfg[`BIT_SYNC_MODE] && !power_down_out && !over_range_a_in
      && !$rose(st.realign_p_sync[1] & ~st.realign_n_sync[1]) |=> !overrange_a_pos_out;
  endproperty
  a_sync_marker: assert property (p_sync_marker) else $error("marker without realign");

  property p_realign_clk;
    st.realign_p_sync[1] && !st.realign_n_sync[1] |=> !data_ready_clock_a_out;
  endproperty
  a_realign_clk: assert property (p_realign_clk) else $error("clock polarity not reset");

  property p_stamp;
    st.ref_cfg[`BIT_SYNC_MODE] && !power_down_out
      && (st.realign_p_sync[1] & ~st.realign_n_sync[1]) && !st.realign_prev
      |=> overrange_a_pos_out && data_a_out == $past(sample_a_in);
  endproperty
  a_stamp: assert property (p_stamp) else $error("sync stamp missing");

  property p_sen_idle;
    st.sen_sync[1] |=> !serial_io_oe_out && !serial_data_oe_out;
  endproperty
  a_sen_idle: assert property (p_sen_idle) else $error("serial drive while disabled");

  property p_four_pin;
    st.serial_cfg[`BIT_FOUR_PIN] |=> !serial_io_oe_out;
  endproperty
  a_four_pin: assert property (p_four_pin) else $error("data pin driven in 4-pin");

  property p_three_pin;
    !st.serial_cfg[`BIT_FOUR_PIN] |=> !serial_data_oe_out;
  endproperty
  a_three_pin: assert property (p_three_pin) else $error("output pin driven in 3-pin");

  property p_irq;
    |(st.irq_status & st.irq_mask) |=> irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  c_serial_write: cover property (st.ser_state == adc_pins_pkg::SER_DATA ##1
                                  st.ser_state == adc_pins_pkg::SER_IDLE);
  c_sync_stamp: cover property (st.ref_cfg[`BIT_SYNC_MODE] && overrange_a_pos_out);
  c_irq: cover property ($rose(irq_out));

endmodule // adc_ctrl_pins
`default_nettype wire

// file: serial_host.sv
`timescale 1ns/1ps
`default_nettype none
module serial_host (
  // serial pins
  output logic     sclk_out,
  output logic     sen_n_out,
  output logic     sd_out,
  output logic     sd_oe_out,
  input  wire logic sdio_in,
  input  wire logic sdo_in,
  input  wire logic four_pin_in
);
  initial begin
    sclk_out = 1'b0;
    sen_n_out = 1'b1;
    sd_out = 1'b0;
    sd_oe_out = 1'b0;
  end
  // sclk stands low between frames; a released line shows the inverse of its last value
  task automatic frame(input logic rd, input logic [6:0] addr, input logic [7:0] wd,
                       output logic [7:0] rdat);
    logic [15:0] word;
    word = {rd, addr, wd};
    rdat = 8'h00;
    // non-blocking, so a pin edge that lands on a clock edge is seen one way only
    sen_n_out <= 1'b0;
    #40;
    for (int i = 15; i >= 0; i--) begin
      sd_oe_out <= !(rd && i < 8);
      sd_out <= (rd && i < 8) ? ~sd_out : word[i];
      #62.5 sclk_out <= 1'b1;
      if (rd && i < 8) rdat = {rdat[6:0], four_pin_in ? sdo_in : sdio_in};
      #62.5 sclk_out <= 1'b0;
    end
    #40 sen_n_out <= 1'b1;
    sd_oe_out <= 1'b0;
    #100;
  endtask
endmodule // serial_host
`default_nettype wire

// file: adc_ctrl_pins_bench.sv
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_pins_bench;
  logic        clock_in, rst_b_in, realign_in_pos_in, realign_in_neg_in, four_pin;
  logic        over_range_a_in, over_range_b_in, reg_wr_in, reg_rd_in, host_sd, host_oe;
  logic [2:0]  pins;
  logic [11:0] sample_a_in, sample_b_in, data_a_out, data_b_out;
  logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out, rv;
  logic        serial_clock_in, serial_enable_n_in, serial_io_out, serial_io_oe_out;
  logic        serial_data_out, serial_data_oe_out, single_bus_out, external_reference_out;
  logic        data_ready_clock_a_out, data_ready_clock_b_out, overrange_a_pos_out;
  logic        overrange_a_neg_out, overrange_b_pos_out, overrange_b_neg_out;
  logic        power_down_out, irq_out;
  wire logic   single_bus_select_pin_in, external_reference_select_pin_in, power_down_pin_in;
  wire logic   serial_io_in, sdo_pin;
  wire logic [2:0] modes = {power_down_out, external_reference_out, single_bus_out};
  wire logic [3:0] ovr = {overrange_a_pos_out, overrange_a_neg_out,
                          overrange_b_pos_out, overrange_b_neg_out};
  int          n_mismatch, cmp_count, n_hi;
  assign {power_down_pin_in, external_reference_select_pin_in, single_bus_select_pin_in} = pins;
  assign serial_io_in = serial_io_oe_out ? serial_io_out : host_sd;
  assign sdo_pin = serial_data_oe_out ? serial_data_out : ~serial_data_out;
  adc_ctrl_pins i_dut (
    .clock_in, .rst_b_in, .single_bus_select_pin_in, .external_reference_select_pin_in,
    .power_down_pin_in, .realign_in_pos_in, .realign_in_neg_in, .sample_a_in, .sample_b_in,
    .over_range_a_in, .over_range_b_in, .serial_clock_in, .serial_enable_n_in, .serial_io_in,
    .serial_io_out, .serial_io_oe_out, .serial_data_out, .serial_data_oe_out, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .data_a_out, .data_b_out,
    .data_ready_clock_a_out, .data_ready_clock_b_out, .overrange_a_pos_out,
    .overrange_a_neg_out, .overrange_b_pos_out, .overrange_b_neg_out, .single_bus_out,
    .external_reference_out, .power_down_out, .irq_out);
  serial_host i_host (
    .sclk_out(serial_clock_in), .sen_n_out(serial_enable_n_in), .sd_out(host_sd),
    .sd_oe_out(host_oe), .sdio_in(serial_io_in), .sdo_in(sdo_pin), .four_pin_in(four_pin));
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out, e);
  endtask
  // the serial pins must never be driven in the wrong mode, frame or no frame
  always @(posedge clock_in) begin
    if (serial_data_oe_out === 1'b1 && !four_pin) chk(1, 0);
    if (serial_io_oe_out === 1'b1 && four_pin) chk(1, 0);
    if (serial_io_oe_out === 1'b1 && host_oe === 1'b1) chk(1, 0);
  end
  task automatic t_reset;
    chk({ovr, irq_out, modes}, 12'h050);
    foreach (rv[i]) rdchk(8'h01 << i, 8'h00);
    rdchk(8'h05, 8'h00);
    rdchk(8'h11, 8'h00);
    wr(8'h33, 8'hff);
    rdchk(8'h33, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_modes;
    for (int k = 0; k < 3; k++) begin
      @(posedge clock_in) pins[k] <= 1'b1;
      cyc(1);
      chk(modes[k], 0);
      cyc(4);
      chk(modes[k], 1);
      @(posedge clock_in) pins[k] <= 1'b0;
      cyc(5);
      chk(modes[k], 0);
      wr(k == 0 ? 8'h02 : 8'h05, k == 0 ? 8'h01 : (k == 1 ? 8'h04 : 8'h40));
      cyc(3);
      chk(modes[k], 1);
      wr(k == 0 ? 8'h02 : 8'h05, 8'h00);
      cyc(3);
      chk(modes[k], 0);
    end
    $display("mode test done");
  endtask
  task automatic t_bus;
    logic c;
    @(posedge clock_in);
    sample_a_in <= 12'h5a3;
    sample_b_in <= 12'ha5c;
    cyc(2);
    chk(data_a_out, 12'h5a3);
    chk(data_b_out, 12'ha5c);
    c = data_ready_clock_b_out;
    cyc(1);
    chk(data_ready_clock_b_out, !c);
    $display("bus test done");
  endtask
  task automatic t_ovr;
    wr(8'h11, 8'h02);
    @(posedge clock_in);
    over_range_a_in <= 1'b1;
    over_range_b_in <= 1'b1;
    cyc(4);
    chk({ovr, irq_out}, 5'h15);
    @(posedge clock_in);
    over_range_a_in <= 1'b0;
    over_range_b_in <= 1'b0;
    cyc(4);
    chk(ovr, 4'h5);
    rdchk(8'h10, 8'h06);
    wr(8'h10, 8'h02);
    cyc(2);
    chk(irq_out, 0);
    rdchk(8'h10, 8'h04);
    wr(8'h10, 8'h04);
    rdchk(8'h10, 8'h00);
    $display("overrange test done");
  endtask
  task automatic t_sync;
    wr(8'h05, 8'h08);
    @(posedge clock_in);
    over_range_a_in <= 1'b1;
    realign_in_pos_in <= 1'b1;
    realign_in_neg_in <= 1'b0;
    n_hi = 0;
    repeat (12) begin
      cyc(1);
      n_hi += int'(overrange_a_pos_out) + int'(overrange_b_pos_out);
    end
    chk(12'(n_hi), 2);
    chk({data_ready_clock_a_out, data_ready_clock_b_out}, 0);
    cyc(1);
    chk({data_ready_clock_a_out, data_ready_clock_b_out}, 0);
    rdchk(8'h10, 8'h01);
    @(posedge clock_in);
    realign_in_pos_in <= 1'b0;
    realign_in_neg_in <= 1'b1;
    over_range_a_in <= 1'b0;
    wr(8'h05, 8'h00);
    wr(8'h10, 8'h01);
    $display("sync test done");
  endtask
  task automatic t_serial;
    i_host.frame(1'b0, 7'h02, 8'h01, rv);
    rdchk(8'h02, 8'h01);
    chk(single_bus_out, 1);
    chk(data_b_out, 12'h000);
    rdchk(8'h10, 8'h08);
    wr(8'h05, 8'h24);
    i_host.frame(1'b1, 7'h05, 8'h00, rv);
    chk(rv, 8'h24);
    wr(8'h01, 8'h01);
    four_pin = 1'b1;
    i_host.frame(1'b1, 7'h05, 8'h00, rv);
    chk(rv, 8'h24);
    i_host.frame(1'b0, 7'h02, 8'h00, rv);
    rdchk(8'h02, 8'h00);
    $display("serial test done");
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    $display("unexpected at %0t: watchdog", $time);
    report_and_stop;
  end
  initial begin
    {rst_b_in, pins, realign_in_pos_in, over_range_a_in, over_range_b_in} = '0;
    {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in, four_pin} = '0;
    {sample_a_in, sample_b_in} = '0;
    realign_in_neg_in = 1'b1;
    repeat (6) @(posedge clock_in);
    rst_b_in <= 1'b1;
    cyc(1);
    t_reset;
    t_modes;
    t_bus;
    t_ovr;
    t_sync;
    t_serial;
    report_and_stop;
  end
endmodule // adc_ctrl_pins_bench
`default_nettype wire
